// *** include/rx_check_regs.svh ***
// Constants for the receive frame checker: byte codes, lengths, CRC and defaults.
// Assumes the includer also compiles rx_check_pkg.
`ifndef RX_CHECK_REGS_SVH
`define RX_CHECK_REGS_SVH

`define PREAMBLE_BYTE 8'h55
`define SFD_BYTE 8'hD5
`define PREAMBLE_LAST 3'h6
`define MIN_DELIVER_LEN 15'h0040
`define NO_STRIP_LEN 15'h0008
`define FCS_LEN 4
`define LINE_DEPTH 68
`define CRC_INIT 32'hFFFFFFFF
`define CRC_POLY 32'hEDB88320
`define CRC_RESIDUE 32'hDEBB20E3

`define DEF_PREAMBLE_CHECK 1'b0
`define DEF_DELIM_CHECK 1'b0
`define DEF_CRC_STRIP 1'b1
`define DEF_CRC_ERR_MASK 1'b0
`define DEF_MAX_LEN 15'h2580
`define DEF_MIN_LEN 8'h40
`define DEF_MARKER_SPACING 16'h3FFF
`define DEF_MARKER_PATTERN0 64'hC16821003E97DE00

`endif

// *** include/rx_check_pkg.sv ***
// Types shared by the receive frame checker.
// Assumes nothing of its surroundings.
package rx_check_pkg;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_PRE = 3'b001,
        S_SFD = 3'b010,
        S_BODY = 3'b011,
        S_DISCARD = 3'b100
    } rx_state_e;

    typedef struct packed {
        logic valid;
        logic sop;
        logic eop;
        logic err;
        logic [7:0] data;
    } slot_s;

endpackage

// *** include/lane_mark_if.sv ***
// Signals between the frame checker top and its lane-marker checker.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
interface lane_mark_if;
    logic word_valid;
    logic [63:0] word;
    logic [63:0] pattern;
    logic [15:0] spacing;
    logic locked;
    logic mismatch;

    modport chk (
        input word_valid,
        input word,
        input pattern,
        input spacing,
        output locked,
        output mismatch
    );
    modport top (
        output word_valid,
        output word,
        output pattern,
        output spacing,
        input locked,
        input mismatch
    );
endinterface

// *** rtl/lane_marker_check.sv ***
// Lane-marker spacing checker for one receive PCS lane.
// Assumes lane words arrive on mclk, one per word_valid cycle.
`timescale 1ns/10ps
module lane_marker_check (
    input wire logic mclk,
    input wire logic reset_n,
    lane_mark_if.chk lm
);
    logic [15:0] gap;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            lm.locked <= 1'b0;
            lm.mismatch <= 1'b0;
            gap <= 16'h0000;
        end else begin
            lm.mismatch <= 1'b0;
            if (lm.word_valid) begin
                if (!lm.locked) begin
                    // Search for the first marker anywhere in the stream
                    if (lm.word == lm.pattern) begin
                        lm.locked <= 1'b1;
                        gap <= lm.spacing;
                    end
                end else if (gap == 16'h0000) begin
                    if (lm.word == lm.pattern) begin
                        gap <= lm.spacing;
                    end else begin
                        lm.locked <= 1'b0;
                        lm.mismatch <= 1'b1;
                    end
                end else begin
                    gap <= gap - 16'h0001;
                end
            end
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    property p_marker_hit;
        !lm.locked && lm.word_valid && lm.word == lm.pattern
            |=> lm.locked && gap == $past(lm.spacing);
    endproperty
    a_marker_hit: assert property (p_marker_hit)
        else $error("marker match did not lock the lane");

    property p_marker_miss;
        lm.locked && lm.word_valid && gap == 16'h0000 && lm.word != lm.pattern
            |=> lm.mismatch && !lm.locked;
    endproperty
    a_marker_miss: assert property (p_marker_miss)
        else $error("missing marker not flagged");

    property p_marker_gap;
        lm.locked && lm.word_valid && gap != 16'h0000
            |=> gap == $past(gap) - 16'h0001 && !lm.mismatch;
    endproperty
    a_marker_gap: assert property (p_marker_gap)
        else $error("marker spacing count wrong");
endmodule

// *** rtl/rx_frame_check_config.sv ***
// Receive frame checker: preamble/delimiter checks, CRC strip and error flag,
// length checks with truncation and drop, and receive lane-marker spacing.
// Assumes one byte per cycle on mclk, with no gaps inside a frame body.
`timescale 1ns/10ps
`include "rx_check_regs.svh"
module rx_frame_check_config (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic in_valid,
    input wire logic in_sop,
    input wire logic in_eop,
    input wire logic [7:0] in_data,
    input wire logic rx_preamble_check_en,
    input wire logic rx_frame_delim_check_en,
    input wire logic rx_crc_strip_en,
    input wire logic rx_crc_err_mask,
    input wire logic [14:0] rx_max_len,
    input wire logic [7:0] rx_min_len,
    input wire logic [15:0] rx_lane_marker_spacing,
    input wire logic [63:0] rx_lane_marker_pattern,
    input wire logic lane_word_valid,
    input wire logic [63:0] lane_word,
    output logic rx_transfer_valid,
    output logic rx_sop,
    output logic rx_eop,
    output logic rx_err,
    output logic [7:0] rx_data,
    output logic stat_good,
    output logic stat_bad_fcs,
    output logic stat_oversize,
    output logic stat_undersize,
    output logic stat_preamble_err,
    output logic rx_lane_locked,
    output logic rx_lane_mismatch
);
    localparam int D = `LINE_DEPTH;

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int k = 0; k < 8; k++) begin
            r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    rx_check_pkg::slot_s line [D];
    rx_check_pkg::slot_s next_line [D];
    rx_check_pkg::rx_state_e state;
    logic [2:0] pre_cnt;
    logic pre_bad;
    logic first;
    logic [14:0] cnt;
    logic [31:0] crc;

    logic cfg_pre;
    logic cfg_sfd;
    logic cfg_strip;
    logic cfg_mask;
    logic [14:0] cfg_max;
    logic [7:0] cfg_min;
    logic [15:0] cfg_spacing;
    logic [63:0] cfg_pattern;

    logic in_body;
    logic over_now;
    logic end_now;
    logic drop;
    logic undersize;
    logic crc_bad;
    logic frame_err;
    logic strip_now;
    logic [14:0] len;
    logic [31:0] next_crc;

    // Settings are static in use; registering them cuts the fan-in paths
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cfg_pre <= `DEF_PREAMBLE_CHECK;
            cfg_sfd <= `DEF_DELIM_CHECK;
            cfg_strip <= `DEF_CRC_STRIP;
            cfg_mask <= `DEF_CRC_ERR_MASK;
            cfg_max <= `DEF_MAX_LEN;
            cfg_min <= `DEF_MIN_LEN;
            cfg_spacing <= `DEF_MARKER_SPACING;
            cfg_pattern <= `DEF_MARKER_PATTERN0;
        end else begin
            cfg_pre <= rx_preamble_check_en;
            cfg_sfd <= rx_frame_delim_check_en;
            cfg_strip <= rx_crc_strip_en;
            cfg_mask <= rx_crc_err_mask;
            cfg_max <= rx_max_len;
            cfg_min <= rx_min_len;
            cfg_spacing <= rx_lane_marker_spacing;
            cfg_pattern <= rx_lane_marker_pattern;
        end
    end

    assign in_body = state == rx_check_pkg::S_BODY && in_valid;
    assign over_now = in_body && cnt == cfg_max;
    assign end_now = in_body && in_eop && !over_now;
    assign len = cnt + 15'h0001;
    assign next_crc = crc_byte(crc, in_data);
    assign crc_bad = next_crc != `CRC_RESIDUE;
    assign drop = len < `MIN_DELIVER_LEN;
    assign undersize = len < {7'h00, cfg_min};
    assign strip_now = cfg_strip && len > `NO_STRIP_LEN;
    assign frame_err = (crc_bad && !cfg_mask) || pre_bad || undersize;

    // Frame sequencer: preamble, delimiter, body, discard of an oversize tail
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state <= rx_check_pkg::S_IDLE;
            pre_cnt <= 3'h0;
            pre_bad <= 1'b0;
            first <= 1'b0;
            cnt <= 15'h0000;
            crc <= `CRC_INIT;
        end else if (in_valid) begin
            unique case (state)
                rx_check_pkg::S_IDLE: begin
                    if (in_sop) begin
                        pre_bad <= cfg_pre && in_data != `PREAMBLE_BYTE;
                        pre_cnt <= 3'h1;
                        state <= rx_check_pkg::S_PRE;
                    end
                end
                rx_check_pkg::S_PRE: begin
                    if (cfg_pre && in_data != `PREAMBLE_BYTE) begin
                        pre_bad <= 1'b1;
                    end
                    pre_cnt <= pre_cnt + 3'h1;
                    if (pre_cnt == `PREAMBLE_LAST) begin
                        state <= rx_check_pkg::S_SFD;
                    end
                end
                rx_check_pkg::S_SFD: begin
                    if (cfg_sfd && in_data != `SFD_BYTE) begin
                        pre_bad <= 1'b1;
                    end
                    cnt <= 15'h0000;
                    crc <= `CRC_INIT;
                    first <= 1'b1;
                    state <= rx_check_pkg::S_BODY;
                end
                rx_check_pkg::S_BODY: begin
                    first <= 1'b0;
                    crc <= next_crc;
                    cnt <= len;
                    if (over_now) begin
                        state <= in_eop ? rx_check_pkg::S_IDLE : rx_check_pkg::S_DISCARD;
                    end else if (in_eop) begin
                        state <= rx_check_pkg::S_IDLE;
                    end
                end
                rx_check_pkg::S_DISCARD: begin
                    if (in_eop) begin
                        state <= rx_check_pkg::S_IDLE;
                    end
                end
                default: begin
                    state <= rx_check_pkg::S_IDLE;
                end
            endcase
        end
    end

    // The delay line holds a whole minimum frame so that a short frame can be
    // withdrawn before any byte of it leaves; the cost is a fixed latency.
    always_comb begin
        next_line[0] = '0;
        for (int i = 1; i < D; i++) begin
            next_line[i] = line[i - 1];
        end
        if (in_body && !over_now) begin
            next_line[0].valid = 1'b1;
            next_line[0].sop = first;
            next_line[0].data = in_data;
        end
        if (over_now) begin
            next_line[1].eop = 1'b1;
            next_line[1].err = 1'b1;
        end
        if (end_now) begin
            if (drop) begin
                for (int i = 0; i < D; i++) begin
                    if (i < int'(len)) begin
                        next_line[i].valid = 1'b0;
                    end
                end
            end else if (strip_now) begin
                for (int i = 0; i < `FCS_LEN; i++) begin
                    next_line[i].valid = 1'b0;
                end
                next_line[`FCS_LEN].eop = 1'b1;
                next_line[`FCS_LEN].err = frame_err;
            end else begin
                next_line[0].eop = 1'b1;
                next_line[0].err = frame_err;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            for (int i = 0; i < D; i++) begin
                line[i] <= '0;
            end
        end else begin
            line <= next_line;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rx_transfer_valid <= 1'b0;
            rx_sop <= 1'b0;
            rx_eop <= 1'b0;
            rx_err <= 1'b0;
            rx_data <= 8'h00;
        end else begin
            rx_transfer_valid <= line[D - 1].valid;
            rx_sop <= line[D - 1].valid && line[D - 1].sop;
            rx_eop <= line[D - 1].valid && line[D - 1].eop;
            rx_err <= line[D - 1].valid && line[D - 1].err;
            rx_data <= line[D - 1].data;
        end
    end

    // Statistic strobes, one cycle each, on the input side: at the frame's end, or at the cut for oversize
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            stat_good <= 1'b0;
            stat_bad_fcs <= 1'b0;
            stat_oversize <= 1'b0;
            stat_undersize <= 1'b0;
            stat_preamble_err <= 1'b0;
        end else begin
            stat_good <= end_now && !drop && !frame_err;
            stat_bad_fcs <= end_now && crc_bad;
            stat_oversize <= over_now;
            stat_undersize <= end_now && undersize;
            stat_preamble_err <= end_now && pre_bad;
        end
    end

    lane_mark_if lm ();
    assign lm.word_valid = lane_word_valid;
    assign lm.word = lane_word;
    assign lm.pattern = cfg_pattern;
    assign lm.spacing = cfg_spacing;
    assign rx_lane_locked = lm.locked;
    assign rx_lane_mismatch = lm.mismatch;

    lane_marker_check u_lane (
        .mclk(mclk),
        .reset_n(reset_n),
        .lm(lm.chk)
    );

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    property p_preamble;
        state == rx_check_pkg::S_PRE && in_valid && cfg_pre && in_data != `PREAMBLE_BYTE
            |=> pre_bad;
    endproperty
    a_preamble: assert property (p_preamble)
        else $error("bad preamble byte not noted");

    property p_sfd;
        state == rx_check_pkg::S_SFD && in_valid && cfg_sfd && in_data != `SFD_BYTE
            |=> pre_bad && state == rx_check_pkg::S_BODY;
    endproperty
    a_sfd: assert property (p_sfd)
        else $error("bad delimiter not noted");

    property p_strip;
        end_now && !drop && strip_now |=> line[4].eop && !line[3].valid && !line[0].valid;
    endproperty
    a_strip: assert property (p_strip)
        else $error("CRC bytes not stripped");

    property p_keep;
        end_now && !drop && !strip_now |=> line[0].eop && line[0].valid;
    endproperty
    a_keep: assert property (p_keep)
        else $error("CRC removed when it must stay");

    property p_fcs_err;
        end_now && !drop && crc_bad && !cfg_mask
            |=> (line[4].eop && line[4].err) || (line[0].eop && line[0].err);
    endproperty
    a_fcs_err: assert property (p_fcs_err)
        else $error("bad CRC not flagged on the end");

    property p_fcs_mask;
        end_now && !drop && crc_bad && cfg_mask && !pre_bad && !undersize
            |=> !line[4].err && !line[0].err ##1 !line[5].err;
    endproperty
    a_fcs_mask: assert property (p_fcs_mask)
        else $error("masked CRC error still flagged");

    property p_stat_mask;
        end_now && !drop && crc_bad && cfg_mask && !pre_bad && !undersize
            |=> stat_bad_fcs && stat_good ##1 !stat_bad_fcs;
    endproperty
    a_stat_mask: assert property (p_stat_mask)
        else $error("masked bad CRC not counted as good");

    property p_oversize;
        over_now |=> line[1].eop && line[1].err && !line[0].valid && stat_oversize;
    endproperty
    a_oversize: assert property (p_oversize)
        else $error("oversize packet not cut");

    property p_undersize;
        end_now && !drop && undersize |=> line[4].err || line[0].err;
    endproperty
    a_undersize: assert property (p_undersize)
        else $error("undersize packet not flagged");

    property p_drop;
        end_now && drop |=> !line[0].valid && !line[1].valid && !stat_good;
    endproperty
    a_drop: assert property (p_drop)
        else $error("short packet not dropped");
endmodule

// *** bench/client_model.sv ***
// Client on the packet bus: collects each delivered frame and checks its form.
// Assumes the bus is sampled on the rising edge of mclk, with no back-pressure.
`timescale 1ns/10ps
module client_model (
    input wire logic mclk,
    input wire logic rx_transfer_valid,
    input wire logic rx_sop,
    input wire logic rx_eop,
    input wire logic rx_err,
    input wire logic [7:0] rx_data
);
    logic [7:0] got_q[$];
    logic last_err;
    int frames = 0;
    int bad_form = 0;
    bit in_frame = 0;

    // The real client cannot stall, so neither does this one
    always @(posedge mclk) begin
        if (rx_transfer_valid === 1'b1) begin
            if (rx_sop === 1'b1) begin
                if (in_frame) bad_form++;
                got_q.delete();
                in_frame = 1;
            end else if (!in_frame) begin
                bad_form++;
            end
            got_q.push_back(rx_data);
            if (rx_eop === 1'b1) begin
                last_err = rx_err;
                frames++;
                in_frame = 0;
            end
        end
        if (rx_err === 1'b1 && !(rx_eop === 1'b1 && rx_transfer_valid === 1'b1)) bad_form++;
    end
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench for the receive frame checker.
// Assumes the design, its constants header and client_model are compiled with it.
`timescale 1ns/10ps
`include "rx_check_regs.svh"
`define CHK(act, exp, msg) begin checks_done++; if ((act) !== (exp)) begin err_total++; \
    $display("ERROR %0t %s", $time, msg); end end
module tb_top;
    typedef struct {
        int len; bit strip; bit mask; bit bad_crc; bit pchk; bit bad_pre; bit dchk; bit bad_del;
        int max_len; int min_len; int n; logic err; logic [4:0] st;
    } row_s;
    localparam int MX = 15'h2580;
    logic mclk, reset_n, in_valid, in_sop, in_eop, lane_word_valid;
    logic rx_preamble_check_en, rx_frame_delim_check_en, rx_crc_strip_en, rx_crc_err_mask;
    logic [7:0] in_data, rx_min_len, rx_data;
    logic [14:0] rx_max_len;
    logic [15:0] rx_lane_marker_spacing;
    logic [63:0] rx_lane_marker_pattern, lane_word, pat;
    logic rx_transfer_valid, rx_sop, rx_eop, rx_err, rx_lane_locked, rx_lane_mismatch;
    logic stat_good, stat_bad_fcs, stat_oversize, stat_undersize, stat_preamble_err;
    logic [4:0] stats, snap, acc;
    logic [7:0] exp_q[$];
    row_s rows[12];
    int err_total = 0;
    int checks_done = 0;
    int start;

    assign stats = {stat_good, stat_bad_fcs, stat_oversize, stat_undersize, stat_preamble_err};

    rx_frame_check_config dut_u (
        .mclk(mclk), .reset_n(reset_n), .in_valid(in_valid), .in_sop(in_sop),
        .in_eop(in_eop), .in_data(in_data), .rx_preamble_check_en(rx_preamble_check_en),
        .rx_frame_delim_check_en(rx_frame_delim_check_en), .rx_crc_strip_en(rx_crc_strip_en),
        .rx_crc_err_mask(rx_crc_err_mask), .rx_max_len(rx_max_len), .rx_min_len(rx_min_len),
        .rx_lane_marker_spacing(rx_lane_marker_spacing),
        .rx_lane_marker_pattern(rx_lane_marker_pattern), .lane_word_valid(lane_word_valid),
        .lane_word(lane_word), .rx_transfer_valid(rx_transfer_valid), .rx_sop(rx_sop),
        .rx_eop(rx_eop), .rx_err(rx_err), .rx_data(rx_data), .stat_good(stat_good),
        .stat_bad_fcs(stat_bad_fcs), .stat_oversize(stat_oversize),
        .stat_undersize(stat_undersize), .stat_preamble_err(stat_preamble_err),
        .rx_lane_locked(rx_lane_locked), .rx_lane_mismatch(rx_lane_mismatch)
    );

    client_model client_u (
        .mclk(mclk), .rx_transfer_valid(rx_transfer_valid), .rx_sop(rx_sop),
        .rx_eop(rx_eop), .rx_err(rx_err), .rx_data(rx_data)
    );

    // Oversize stats fire mid-frame, so pulses are gathered over the whole frame
    always @(posedge mclk) acc <= acc | stats;

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    function automatic logic [31:0] crc_next(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c ^ {24'h000000, b};
        for (int k = 0; k < 8; k++) r = r[0] ? ((r >> 1) ^ 32'hEDB88320) : (r >> 1);
        return r;
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic send_frame(input int len, input bit bad_crc, input bit bad_pre,
                              input bit bad_del);
        logic [31:0] c;
        c = 32'hFFFFFFFF;
        exp_q.delete();
        for (int i = 0; i < len - 4; i++) begin
            exp_q.push_back(8'(i * 7 + 3));
            c = crc_next(c, exp_q[i]);
        end
        c = ~c ^ {bad_crc, 31'h00000000};
        for (int i = 0; i < 4; i++) exp_q.push_back(c[8*i +: 8]);
        for (int i = 0; i < len + 8; i++) begin
            in_valid = 1'b1;
            in_sop = (i == 0);
            in_eop = (i == len + 7);
            if (i < 7) in_data = (bad_pre && i == 3) ? 8'h54 : 8'h55;
            else if (i == 7) in_data = bad_del ? 8'hD4 : 8'hD5;
            else in_data = exp_q[i - 8];
            @(posedge mclk);
            #1;
        end
        in_valid = 1'b0;
        in_sop = 1'b0;
        in_eop = 1'b0;
        snap = stats;
    endtask

    task automatic wait_frame(input bit none);
        int k;
        k = 0;
        while (client_u.frames == start && k < 150) begin
            @(posedge mclk);
            #1;
            k++;
        end
        if (k == 150 && !none) begin
            err_total++;
            $display("ERROR %0t no frame delivered", $time);
            results();
        end
    endtask

    // Holds valid up between words; the caller lowers it after the burst
    task automatic send_lane_word(input logic [63:0] w);
        lane_word_valid = 1'b1;
        lane_word = w;
        @(posedge mclk);
        #1;
    endtask

    initial begin
        reset_n = 1'b0;
        {in_valid, in_sop, in_eop, in_data, lane_word_valid, lane_word} = '0;
        {rx_preamble_check_en, rx_frame_delim_check_en, rx_crc_err_mask} = 3'h0;
        rx_crc_strip_en = 1'b1;
        rx_max_len = `DEF_MAX_LEN;
        rx_min_len = `DEF_MIN_LEN;
        rx_lane_marker_spacing = `DEF_MARKER_SPACING;
        rx_lane_marker_pattern = `DEF_MARKER_PATTERN0;
        acc = 5'h00;
        rows = '{
            '{64, 1, 0, 0, 0, 0, 0, 0, MX, 64, 60, 0, 5'h10},
            '{64, 0, 0, 0, 0, 0, 0, 0, MX, 64, 64, 0, 5'h10},
            '{70, 1, 0, 1, 0, 0, 0, 0, MX, 64, 66, 1, 5'h08},
            '{70, 1, 1, 1, 0, 0, 0, 0, MX, 64, 66, 0, 5'h18},
            '{100, 1, 0, 0, 0, 0, 0, 0, 80, 64, 80, 1, 5'h04},
            '{80, 1, 0, 0, 0, 0, 0, 0, 80, 64, 76, 0, 5'h10},
            '{63, 1, 0, 0, 0, 0, 0, 0, MX, 64, 0, 0, 5'h02},
            '{70, 1, 0, 0, 0, 0, 0, 0, MX, 80, 66, 1, 5'h02},
            '{64, 1, 0, 0, 1, 1, 0, 0, MX, 64, 60, 1, 5'h01},
            '{64, 1, 0, 0, 0, 1, 0, 0, MX, 64, 60, 0, 5'h10},
            '{64, 1, 0, 0, 0, 0, 1, 1, MX, 64, 60, 1, 5'h01},
            '{64, 1, 0, 0, 0, 0, 0, 1, MX, 64, 60, 0, 5'h10}
        };
        repeat (4) @(posedge mclk);
        #1;
        `CHK({rx_transfer_valid, rx_err, stats, rx_lane_locked}, 8'h00, "reset outputs")
        reset_n = 1'b1;
        for (int r = 0; r < 12; r++) begin
            rx_crc_strip_en = rows[r].strip;
            rx_crc_err_mask = rows[r].mask;
            rx_preamble_check_en = rows[r].pchk;
            rx_frame_delim_check_en = rows[r].dchk;
            rx_max_len = 15'(rows[r].max_len);
            rx_min_len = 8'(rows[r].min_len);
            repeat (3) @(posedge mclk);
            #1;
            acc = 5'h00;
            start = client_u.frames;
            send_frame(rows[r].len, rows[r].bad_crc, rows[r].bad_pre, rows[r].bad_del);
            wait_frame(rows[r].n == 0);
            `CHK(acc, rows[r].st, "stat set")
            if (rows[r].st[2] == 1'b0) `CHK(snap, rows[r].st, "stat timing")
            `CHK(client_u.frames - start, (rows[r].n != 0) ? 1 : 0, "frame count")
            if (rows[r].n != 0) begin
                `CHK(client_u.got_q.size(), rows[r].n, "length")
                `CHK(client_u.last_err, rows[r].err, "error flag")
                for (int i = 0; i < rows[r].n; i++) begin
                    `CHK(client_u.got_q[i], exp_q[i], "data")
                end
            end
            $display("frame row %0d done", r);
        end
        for (int t = 0; t < 2; t++) begin
            pat = (t == 0) ? `DEF_MARKER_PATTERN0 : 64'h0123456789ABCDEF;
            rx_lane_marker_pattern = pat;
            rx_lane_marker_spacing = (t == 0) ? 16'h0003 : 16'h0006;
            repeat (2) @(posedge mclk);
            #1;
            send_lane_word(~pat);
            `CHK(rx_lane_locked, 1'b0, "locked on noise")
            send_lane_word(pat);
            `CHK(rx_lane_locked, 1'b1, "no lock on marker")
            for (int m = 0; m < 2; m++) begin
                repeat (rx_lane_marker_spacing) send_lane_word(~pat);
                send_lane_word((m == 0) ? pat : ~pat);
                `CHK(rx_lane_mismatch, 1'(m), "marker mismatch")
                `CHK(rx_lane_locked, 1'(1 - m), "lock state")
            end
            lane_word_valid = 1'b0;
            $display("lane case %0d done", t);
        end
        // A reset in mid-run must drop the lock and leave no frame state behind
        send_lane_word(pat);
        lane_word_valid = 1'b0;
        `CHK(rx_lane_locked, 1'b1, "relock")
        reset_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        `CHK({rx_transfer_valid, rx_err, stats, rx_lane_locked}, 8'h00, "mid-run reset")
        reset_n = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        acc = 5'h00;
        start = client_u.frames;
        send_frame(64, 1'b0, 1'b0, 1'b0);
        wait_frame(1'b0);
        `CHK(acc, 5'h10, "frame after reset")
        `CHK(client_u.got_q.size(), 60, "length after reset")
        $display("reset case done");
        `CHK(client_u.bad_form, 0, "bus form")
        results();
    end
endmodule
